/* dv/mrsc_reset_switch.sv */
// behavioural model of the external reset switch with its rc network on the reset pin
`timescale 1ns/1ps
module mrsc_reset_switch #(
  parameter int RC_CYCLES = 3
) (
  input wire logic sys_clk_i,
  input wire logic press_i,
  output logic external_clear_pin_n_o
);
  int rc_q = 0;

  // the capacitor keeps the pin low a few cycles after the switch opens; the pull-up then wins
  always_ff @(posedge sys_clk_i) begin
    if (press_i) begin
      rc_q <= RC_CYCLES;
    end else if (rc_q > 0) begin
      rc_q <= rc_q - 1;
    end
  end

  assign external_clear_pin_n_o = !(press_i || rc_q > 0);
endmodule : mrsc_reset_switch

/* dv/tb_top.sv */
// self-checking bench for the reset source controller: reset causes, flags and register defaults
`timescale 1ns/1ps
`include "mrsc_params.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module tb_top
  import mrsc_pkg::*;
;
  localparam int ST = 4;
  logic sys_clk_i;
  logic rst_i;
  logic press;
  logic pin_n;
  logic low_supply_clear;
  logic wdt;
  logic halt;
  logic clrw;
  mrsc_apb_req_s req;
  mrsc_apb_rsp_s rsp;
  mrsc_ctl_s ctl;
  mrsc_byte_t [`MRSC_NREG-1:0] regv;
  int mismatches;
  int n_compared;
  int cycles;
  int n;
  // registers written before a reset and what each should hold afterwards
  int idx[4] = '{1, 4, 8, 13};
  logic [7:0] wv[4] = '{8'h03, 8'h12, 8'h00, 8'hA5};
  logic [7:0] dv[4] = '{8'h07, 8'h00, 8'hFF, 8'hA5};
  // power-on values of indices 1..12
  logic [7:0] por[13] = '{8'h00, 8'h07, 8'h00, 8'h00, 8'h00, 8'h40, 8'h00, 8'h40,
    8'hFF, 8'hFF, 8'h0F, 8'h0F, 8'h00};

  mrsc_top #(.START_CYCLES(ST)) dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .external_clear_pin_n_i(pin_n), .low_supply_clear_i(low_supply_clear), .wdt_expired_i(wdt),
    .halt_exec_i(halt), .clr_wdt_exec_i(clrw), .apb_req_i(req), .apb_rsp_o(rsp),
    .ctl_o(ctl), .reg_values_o(regv));

  mrsc_reset_switch #(.RC_CYCLES(3)) sw (.sys_clk_i(sys_clk_i), .press_i(press),
    .external_clear_pin_n_o(pin_n));

  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  // hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      close_out();
    end
  end

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out

  // one apb transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input int i, input logic [7:0] d, output logic [7:0] q,
                     output logic err);
    @(posedge sys_clk_i);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= wr;
    req.paddr <= 8'(i * 4);
    req.pwdata <= {24'h000000, d};
    req.pstrb <= 4'hF;
    @(posedge sys_clk_i);
    req.penable <= 1'b1;
    // no timeout here; if pready never comes only the hang guard ends this wait
    do begin
      @(posedge sys_clk_i);
    end while (rsp.pready !== 1'b1);
    q = rsp.prdata[7:0];
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  task automatic rd(input int i, input logic [7:0] e, input string nm);
    logic [7:0] q;
    logic err;
    apb(1'b0, i, 8'h00, q, err);
    `CHK(nm, e, q)
  endtask : rd

  task automatic prep();
    logic [7:0] q;
    logic err;
    for (int k = 0; k < 4; k++) apb(1'b1, idx[k], wv[k], q, err);
  endtask : prep

  // dflt: reset reloaded the defaults; otherwise everything must be untouched
  task automatic check_regs(input bit dflt);
    for (int k = 0; k < 4; k++) rd(idx[k], dflt ? dv[k] : wv[k], "reg after reset");
  endtask : check_regs

  task automatic wait_run(output int c);
    c = 0;
    while (ctl.cpu_run !== 1'b1) begin
      @(posedge sys_clk_i);
      c++;
    end
  endtask : wait_run

  task automatic tick(input int c);
    repeat (c) @(posedge sys_clk_i);
  endtask : tick

  task automatic por_reset();
    rst_i <= 1'b1;
    tick(4);
    `CHK("sp_top in reset", 1'b1, ctl.sp_top)
    `CHK("prescaler_clear in reset", 1'b1, ctl.prescaler_clear)
    `CHK("wdt_clear in reset", 1'b1, ctl.wdt_clear)
    `CHK("pc_clear in reset", 1'b1, ctl.pc_clear)
    rst_i <= 1'b0;
    wait_run(n);
  endtask : por_reset

  initial begin
    press = 1'b0;
    low_supply_clear = 1'b0;
    wdt = 1'b0;
    halt = 1'b0;
    clrw = 1'b0;
    req = '0;
    mismatches = 0;
    n_compared = 0;
    cycles = 0;
    por_reset();
    rd(0, 8'h00, "status after power-on");
    for (int i = 1; i < 13; i++) rd(i, por[i], "power-on value");
    $display("test power_on done");

    // pin reset while running: defaults reloaded, flags and data kept, start-up delay
    prep();
    press <= 1'b1;
    tick(6);
    `CHK("pc_clear during pin", 1'b1, ctl.pc_clear)
    `CHK("cpu_run during pin", 1'b0, ctl.cpu_run)
    press <= 1'b0;
    while (pin_n !== 1'b1) @(posedge sys_clk_i);
    wait_run(n);
    `CHK("start delay", 1'b1, n >= ST && n <= ST + 5)
    rd(0, 8'h00, "status after pin");
    check_regs(1'b1);
    `CHK("port a latch output", 8'hFF, regv[`MRSC_IDX_PA_LATCH])
    $display("test pin_reset done");

    // watchdog expiry while running
    prep();
    wdt <= 1'b1;
    tick(1);
    wdt <= 1'b0;
    tick(2);
    `CHK("pc_clear after wdt", 1'b1, ctl.pc_clear)
    wait_run(n);
    rd(0, 8'h01, "status after run wdt");
    check_regs(1'b1);
    $display("test run_watchdog done");

    // low supply reset keeps flags
    prep();
    low_supply_clear <= 1'b1;
    tick(6);
    `CHK("cpu_run during lvr", 1'b0, ctl.cpu_run)
    low_supply_clear <= 1'b0;
    wait_run(n);
    rd(0, 8'h01, "status after lvr");
    check_regs(1'b1);
    $display("test low_supply done");

    // halt, then watchdog expiry while asleep
    prep();
    halt <= 1'b1;
    tick(1);
    halt <= 1'b0;
    tick(2);
    `CHK("sleeping", 1'b1, ctl.sleeping)
    rd(0, 8'h02, "status after halt");
    wdt <= 1'b1;
    tick(1);
    wdt <= 1'b0;
    tick(2);
    `CHK("sp_clear after sleep wdt", 1'b1, ctl.sp_clear)
    `CHK("pc_clear after sleep wdt", 1'b1, ctl.pc_clear)
    wait_run(n);
    rd(0, 8'h03, "status after sleep wdt");
    check_regs(1'b0);
    `CHK("setup output after sleep wdt", 8'h03, regv[`MRSC_IDX_WDT_SETUP])
    $display("test sleep_watchdog done");

    // clear-watchdog instruction drops the sleep flag only
    clrw <= 1'b1;
    tick(1);
    clrw <= 1'b0;
    tick(2);
    rd(0, 8'h01, "status after clear wdt");
    $display("test clear_watchdog done");

    // unmapped address answers with an error and zero data
    begin
      logic [7:0] q;
      logic err;
      apb(1'b0, `MRSC_NREG, 8'h00, q, err);
      `CHK("unmapped error", 1'b1, err)
      `CHK("unmapped data", 8'h00, q)
    end
    $display("test unmapped done");

    // second power-on clears flags and the kept data
    por_reset();
    rd(0, 8'h00, "status after second power-on");
    rd(`MRSC_IDX_ACC, `MRSC_INIT_UNDEF, "acc after power-on");
    $display("test second_power_on done");
    close_out();
  end
endmodule : tb_top

/* rtl/mrsc_params.svh */
// constants for the reset source controller: timing, register indices, reset values and masks
`ifndef MRSC_PARAMS_SVH
`define MRSC_PARAMS_SVH

// system clock period and start-up delay after a reset is released
`define MRSC_CLK_PERIOD_NS 4
`define MRSC_RSTD_NS 1000

// bus geometry: byte address is index times four
`define MRSC_ADDR_W 8
`define MRSC_NREG 22
`define MRSC_CNT_W 16

// registers from this index up keep their content over every reset but power-on
`define MRSC_FIRST_KEEP 13

// register indices
`define MRSC_IDX_STATUS 0
`define MRSC_IDX_WDT_SETUP 1
`define MRSC_IDX_IRQ_MAIN 2
`define MRSC_IDX_IRQ_UPPER 3
`define MRSC_IDX_T0_COUNT 4
`define MRSC_IDX_T0_CTRL 5
`define MRSC_IDX_T1_COUNT 6
`define MRSC_IDX_T1_CTRL 7
`define MRSC_IDX_PA_LATCH 8
`define MRSC_IDX_PA_DIR 9
`define MRSC_IDX_PB_LATCH 10
`define MRSC_IDX_PB_DIR 11
`define MRSC_IDX_MOD_CTRL 12
`define MRSC_IDX_ACC 13
`define MRSC_IDX_TBL_PTR 14
`define MRSC_IDX_TBL_HIGH 15
`define MRSC_IDX_MEM_PTR 16
`define MRSC_IDX_CONV_LOW 17
`define MRSC_IDX_CONV_HIGH 18
`define MRSC_IDX_DUTY_LOW 19
`define MRSC_IDX_DUTY_HIGH 20
`define MRSC_IDX_VOLUME 21

// status bit positions
`define MRSC_ST_WDT_BIT 0
`define MRSC_ST_SLEEP_BIT 1

// reset values
`define MRSC_INIT_WDT_SETUP 8'h07
`define MRSC_INIT_IRQ 8'h00
`define MRSC_INIT_T_COUNT 8'h00
`define MRSC_INIT_T_CTRL 8'h40
`define MRSC_INIT_PORT_A 8'hFF
`define MRSC_INIT_PORT_B 8'h0F
`define MRSC_INIT_MOD_CTRL 8'h00
`define MRSC_INIT_UNDEF 8'h00

// implemented-bit masks; unimplemented bits read as zero
`define MRSC_MASK_FULL 8'hFF
`define MRSC_MASK_IRQ_MAIN 8'h7F
`define MRSC_MASK_NIBBLE 8'h0F
`define MRSC_MASK_MOD_CTRL 8'h1F
`define MRSC_MASK_MEM_PTR 8'h7F
`define MRSC_MASK_VOLUME 8'hF7

`endif

/* rtl/mrsc_pkg.sv */
// types shared by the reset source controller files
package mrsc_pkg;
  `include "mrsc_params.svh"

  typedef logic [7:0] mrsc_byte_t;

  // apb request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [`MRSC_ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } mrsc_apb_req_s;

  // apb answer to the master
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } mrsc_apb_rsp_s;

  // controls toward the core
  typedef struct packed {
    logic pc_clear;
    logic sp_top;
    logic sp_clear;
    logic wdt_clear;
    logic prescaler_clear;
    logic cpu_run;
    logic sleeping;
  } mrsc_ctl_s;

  typedef enum logic [1:0] {ST_HOLD, ST_START, ST_RUN, ST_SLEEP} mrsc_state_e;
endpackage : mrsc_pkg

/* rtl/mrsc_reg_cell.sv */
// one byte register with power-on value, reset reload and bus write
`timescale 1ns/1ps
module mrsc_reg_cell #(
  parameter logic [7:0] INIT = 8'h00,
  parameter logic [7:0] MASK = 8'hFF,
  parameter bit SOFT = 1'b1
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic soft_load_i,
  input wire logic wr_en_i,
  input wire mrsc_pkg::mrsc_byte_t wr_data_i,
  output mrsc_pkg::mrsc_byte_t value_o
);
  import mrsc_pkg::*;

  mrsc_byte_t value_q;

  // reset reload beats a write in the same cycle, so a held reset cannot be undone by software
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      value_q <= INIT;
    end else if (soft_load_i && SOFT) begin
      value_q <= INIT;
    end else if (wr_en_i) begin
      value_q <= wr_data_i & MASK;
    end
  end

  assign value_o = value_q;
endmodule : mrsc_reg_cell

/* rtl/mrsc_top.sv */
// reset source controller: reset classification, cause flags, register defaults, apb slave
// Operation
// R01: pin pulled low while running clears program counter, restarts at zero after release
// R02: watchdog expiry while running acts like pin reset plus watchdog flag set
// R03: watchdog expiry in sleep clears only program counter, stack pointer, sets flag
// R04: status register holds watchdog and sleep flags for software to read
// R05: power-on reset clears both cause flags
// R06: pin or low-supply reset while running keeps both cause flags
// R07: watchdog reset while running sets watchdog flag, keeps sleep flag
// R08: watchdog reset from sleep leaves both flags at one
// R09: power-on reset leaves every interrupt enable off
// R10: power-on reset clears the watchdog counter, which then counts at once
// R11: power-on reset stops timers and clears the timer prescaler
// R12: power-on, pin, running watchdog reset set port latches and directions all ones
// R13: power-on reset points stack pointer at top of return stack
// R14: watchdog setup loads 07 on every reset except watchdog from sleep
// R15: timer counts load 00, controls 40 except on watchdog from sleep
// R16: data registers undefined at power-on, kept by every other reset
// R17: halt sets sleep flag and clears watchdog flag
// R18: power-up and clear-watchdog instruction clear the sleep flag
// R19: after pin release wait a start-up delay before running
// R20: reset pin is synchronised to the system clock before use
`timescale 1ns/1ps
`include "mrsc_params.svh"
module mrsc_top #(
  parameter int unsigned START_CYCLES =
    (`MRSC_RSTD_NS + `MRSC_CLK_PERIOD_NS - 1) / `MRSC_CLK_PERIOD_NS
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic external_clear_pin_n_i,
  input wire logic low_supply_clear_i,
  input wire logic wdt_expired_i,
  input wire logic halt_exec_i,
  input wire logic clr_wdt_exec_i,
  input wire mrsc_pkg::mrsc_apb_req_s apb_req_i,
  output mrsc_pkg::mrsc_apb_rsp_s apb_rsp_o,
  output mrsc_pkg::mrsc_ctl_s ctl_o,
  output mrsc_pkg::mrsc_byte_t [`MRSC_NREG-1:0] reg_values_o
);
  import mrsc_pkg::*;

  localparam int NREG = `MRSC_NREG;
  localparam int CNT_W = `MRSC_CNT_W;

  // power-on values, index order
  localparam mrsc_byte_t INIT_TAB [NREG] = '{
    8'h00, `MRSC_INIT_WDT_SETUP, `MRSC_INIT_IRQ, `MRSC_INIT_IRQ,
    `MRSC_INIT_T_COUNT, `MRSC_INIT_T_CTRL, `MRSC_INIT_T_COUNT, `MRSC_INIT_T_CTRL,
    `MRSC_INIT_PORT_A, `MRSC_INIT_PORT_A, `MRSC_INIT_PORT_B, `MRSC_INIT_PORT_B,
    `MRSC_INIT_MOD_CTRL, `MRSC_INIT_UNDEF, `MRSC_INIT_UNDEF, `MRSC_INIT_UNDEF,
    `MRSC_INIT_UNDEF, `MRSC_INIT_UNDEF, `MRSC_INIT_UNDEF, `MRSC_INIT_UNDEF,
    `MRSC_INIT_UNDEF, `MRSC_INIT_UNDEF
  };

  // implemented bits, index order
  localparam mrsc_byte_t MASK_TAB [NREG] = '{
    8'h00, `MRSC_MASK_FULL, `MRSC_MASK_IRQ_MAIN, `MRSC_MASK_NIBBLE,
    `MRSC_MASK_FULL, `MRSC_MASK_FULL, `MRSC_MASK_FULL, `MRSC_MASK_FULL,
    `MRSC_MASK_FULL, `MRSC_MASK_FULL, `MRSC_MASK_NIBBLE, `MRSC_MASK_NIBBLE,
    `MRSC_MASK_MOD_CTRL, `MRSC_MASK_FULL, `MRSC_MASK_FULL, `MRSC_MASK_FULL,
    `MRSC_MASK_MEM_PTR, `MRSC_MASK_NIBBLE, `MRSC_MASK_FULL, `MRSC_MASK_NIBBLE,
    `MRSC_MASK_FULL, `MRSC_MASK_VOLUME
  };

  logic pin_s1_q;
  logic pin_s2_q;
  logic lvr_s1_q;
  logic lvr_s2_q;
  mrsc_state_e state_q;
  mrsc_state_e state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic wdt_flag_q;
  logic wdt_flag_d;
  logic sleep_flag_q;
  logic sleep_flag_d;
  logic por_q;
  logic wake_q;
  logic first_q;
  logic [31:0] prdata_q;
  logic err_q;
  logic [CNT_W-1:0] start_len_q;
  wire mrsc_byte_t [NREG-1:0] regs_w;

  // two-stage synchronisers; the pin resets to "held low" so nothing runs before it is seen high
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      lvr_s1_q <= 1'b0;
      lvr_s2_q <= 1'b0;
    end else begin
      pin_s1_q <= external_clear_pin_n_i; // R20
      pin_s2_q <= pin_s1_q; // R20
      lvr_s1_q <= low_supply_clear_i;
      lvr_s2_q <= lvr_s1_q;
    end
  end

  // reset event classification from the synchronised levels and the core pulses
  wire pin_low_w = ~pin_s2_q;
  wire hold_req_w = pin_low_w | lvr_s2_q;
  wire in_run_w = (state_q == ST_RUN);
  wire in_sleep_w = (state_q == ST_SLEEP);
  wire wdt_run_w = in_run_w & wdt_expired_i & ~hold_req_w;
  wire wdt_sleep_w = in_sleep_w & wdt_expired_i & ~hold_req_w;
  wire halt_w = in_run_w & halt_exec_i & ~wdt_expired_i & ~hold_req_w;
  // a clear-watchdog in the cycle of an expiry is dropped, so the expiry keeps the sleep flag
  wire clrwdt_w = in_run_w & clr_wdt_exec_i & ~wdt_expired_i & ~hold_req_w; // R07
  wire start_done_w = (cnt_q == CNT_W'(START_CYCLES - 1));

  // registers reload while the pin or low supply is held and on a running watchdog expiry;
  // a watchdog expiry in sleep does not reload them
  wire soft_load_w = hold_req_w | (state_q == ST_HOLD) | wdt_run_w; // R02 R12 R14 R15

  // sequencer: hold while asserted, count the start-up delay, then run
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      ST_HOLD: begin
        if (!hold_req_w) begin
          state_d = ST_START;
          cnt_d = '0;
        end
      end
      ST_START: begin
        if (hold_req_w) begin
          state_d = ST_HOLD;
        end else if (start_done_w) begin
          state_d = ST_RUN; // R19
        end else begin
          cnt_d = cnt_q + CNT_W'(1); // R19
        end
      end
      ST_RUN: begin
        if (hold_req_w) begin
          state_d = ST_HOLD; // R01
        end else if (wdt_run_w) begin
          state_d = ST_START; // R02
          cnt_d = '0;
        end else if (halt_w) begin
          state_d = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (hold_req_w) begin
          state_d = ST_HOLD;
        end else if (wdt_sleep_w) begin
          state_d = ST_START; // R03
          cnt_d = '0;
        end
      end
      default: begin
        state_d = ST_HOLD;
        cnt_d = '0;
      end
    endcase
  end

  // cause flags: a watchdog set is applied last so it wins over the halt clear
  always_comb begin
    wdt_flag_d = wdt_flag_q; // R06
    sleep_flag_d = sleep_flag_q; // R06
    if (clrwdt_w) begin
      sleep_flag_d = 1'b0; // R18
    end
    if (halt_w) begin
      wdt_flag_d = 1'b0; // R17
      sleep_flag_d = 1'b1; // R17
    end
    if (wdt_run_w || wdt_sleep_w) begin
      wdt_flag_d = 1'b1; // R07 R08
    end
  end

  // state, counter and flags
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= ST_HOLD;
      cnt_q <= '0;
      wdt_flag_q <= 1'b0; // R05
      sleep_flag_q <= 1'b0; // R05 R18
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      wdt_flag_q <= wdt_flag_d;
      sleep_flag_q <= sleep_flag_d;
    end
  end

  // power-on marker lasts until the first run; wake marker until the wake-up finishes
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      por_q <= 1'b1;
      wake_q <= 1'b0;
      first_q <= 1'b1;
    end else begin
      por_q <= por_q & (state_d != ST_RUN);
      wake_q <= wdt_sleep_w | (wake_q & (state_d != ST_RUN) & ~hold_req_w);
      first_q <= 1'b0;
    end
  end

  // core controls: pc held at zero through hold and start-up
  assign ctl_o.pc_clear = (state_q == ST_HOLD) | (state_q == ST_START); // R01 R03
  assign ctl_o.sp_top = por_q; // R13
  assign ctl_o.sp_clear = wake_q; // R03
  assign ctl_o.wdt_clear = first_q | halt_w; // R10
  assign ctl_o.prescaler_clear = first_q; // R11
  assign ctl_o.cpu_run = in_run_w;
  assign ctl_o.sleeping = in_sleep_w;

  // apb decode; one aligned word per register, unmapped or misaligned answers with an error
  wire setup_w = apb_req_i.psel & ~apb_req_i.penable;
  wire access_w = apb_req_i.psel & apb_req_i.penable;
  wire [5:0] idx_w = apb_req_i.paddr[7:2];
  wire hit_w = (apb_req_i.paddr[1:0] == 2'h0) && (idx_w < 6'(NREG));
  wire wr_w = access_w & apb_req_i.pwrite & hit_w & apb_req_i.pstrb[0];
  wire mrsc_byte_t wdata_w = apb_req_i.pwdata[7:0];
  wire mrsc_byte_t rd_byte_w = hit_w ? regs_w[idx_w[4:0]] : 8'h00;

  // status word: flags only, other bits zero; writes to it are ignored
  assign regs_w[`MRSC_IDX_STATUS] = {6'h00, sleep_flag_q, wdt_flag_q}; // R04

  // register bank; data registers from the keep index up survive every non power-on reset
  for (genvar i = 1; i < NREG; i++) begin : g_reg
    mrsc_reg_cell #(
      .INIT(INIT_TAB[i]), // R09 R12 R14 R15
      .MASK(MASK_TAB[i]),
      .SOFT(i < `MRSC_FIRST_KEEP) // R16
    ) u_cell (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .soft_load_i(soft_load_w),
      .wr_en_i(wr_w && (idx_w == 6'(i))),
      .wr_data_i(wdata_w),
      .value_o(regs_w[i])
    );
  end

  // read data captured in the setup cycle so prdata leaves a flop; zero wait states
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
    end else if (setup_w) begin
      prdata_q <= {24'h00_0000, rd_byte_w}; // R04
      err_q <= ~hit_w;
    end
  end

  assign apb_rsp_o.pready = access_w;
  assign apb_rsp_o.pslverr = access_w & err_q;
  assign apb_rsp_o.prdata = prdata_q;
  assign reg_values_o = regs_w;

  // helper: length of the current start-up phase
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      start_len_q <= '0;
    end else if (state_q == ST_START) begin
      start_len_q <= start_len_q + CNT_W'(1);
    end else begin
      start_len_q <= '0;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_wdt_in_sleep;
    in_sleep_w && wdt_expired_i && !hold_req_w && !wr_w;
  endsequence

  sequence s_wdt_in_run;
    in_run_w && wdt_expired_i && !hold_req_w;
  endsequence

  sequence s_released;
    (state_q == ST_HOLD) && !hold_req_w;
  endsequence

  a_pin_forces_hold: assert property (pin_low_w |=> state_q == ST_HOLD && ctl_o.pc_clear) // R01
    else $error("pin low did not hold the core with pc cleared");

  a_release_starts: assert property (s_released |=> state_q == ST_START && !ctl_o.cpu_run) // R19
    else $error("release did not enter start-up");

  a_start_length: assert property ($rose(ctl_o.cpu_run) |-> start_len_q == 16'(START_CYCLES)) // R19
    else $error("start-up delay has the wrong length");

  a_wdt_run_flags: assert property (s_wdt_in_run |=> wdt_flag_q && !ctl_o.cpu_run
      && sleep_flag_q == $past(sleep_flag_q) && regs_w[`MRSC_IDX_PA_DIR] == 8'hFF) // R02 R07
    else $error("running watchdog reset gave wrong flags or state");

  a_wdt_sleep_keep: assert property (s_wdt_in_sleep |=> wdt_flag_q && sleep_flag_q
      && ctl_o.sp_clear && ctl_o.pc_clear && $stable(regs_w[`MRSC_IDX_WDT_SETUP])
      && $stable(regs_w[`MRSC_IDX_T0_CTRL]) && $stable(regs_w[`MRSC_IDX_PA_LATCH])) // R03 R08
    else $error("watchdog wake from sleep disturbed state");

  a_hold_keeps_flags: assert property (hold_req_w |=> $stable(wdt_flag_q) && $stable(sleep_flag_q)) // R06
    else $error("pin or low-supply reset changed the cause flags");

  a_halt_flags: assert property (halt_w |=> sleep_flag_q && !wdt_flag_q && ctl_o.sleeping) // R17
    else $error("halt did not set sleep and clear watchdog flag");

  a_clrwdt_sleep: assert property (clrwdt_w && !halt_w |=> !sleep_flag_q) // R18
    else $error("clear-watchdog did not clear the sleep flag");

  a_hold_defaults: assert property ((state_q == ST_HOLD) |=> regs_w[`MRSC_IDX_WDT_SETUP] == 8'h07
      && regs_w[`MRSC_IDX_T0_COUNT] == 8'h00 && regs_w[`MRSC_IDX_T1_CTRL] == 8'h40
      && regs_w[`MRSC_IDX_PA_LATCH] == 8'hFF && regs_w[`MRSC_IDX_IRQ_MAIN] == 8'h00) // R12 R14 R15
    else $error("register defaults not applied during hold");

  a_por_first: assert property (first_q |-> !wdt_flag_q && !sleep_flag_q && ctl_o.wdt_clear
      && ctl_o.prescaler_clear && ctl_o.sp_top && regs_w[`MRSC_IDX_IRQ_UPPER] == 8'h00) // R05 R09 R10 R11 R13
    else $error("power-on state is wrong");

  a_keep_data: assert property (soft_load_w && !wr_w |=> $stable(regs_w[`MRSC_IDX_ACC])
      && $stable(regs_w[`MRSC_IDX_VOLUME])) // R16
    else $error("data register lost its value on a reset");

  a_status_read: assert property (setup_w && !apb_req_i.pwrite && apb_req_i.paddr == 8'h00
      |=> apb_rsp_o.prdata == {30'h0, $past(sleep_flag_q), $past(wdt_flag_q)}) // R04
    else $error("status read does not show the cause flags");

  sequence s_unmapped_access;
    setup_w && !hit_w ##1 access_w;
  endsequence

  a_pin_two_flops: assert property (!pin_s1_q |=> pin_low_w) // R20
    else $error("pin low was not passed through the second synchroniser stage");

  a_lvr_forces_hold: assert property (lvr_s2_q |=> state_q == ST_HOLD && !ctl_o.cpu_run) // R06
    else $error("low-supply reset did not hold the core");

  a_unmapped_err: assert property (s_unmapped_access |-> apb_rsp_o.pslverr // R04
      && apb_rsp_o.prdata == 32'h0000_0000)
    else $error("unmapped access did not answer with an error and zero data");

  a_wake_sp_clear: assert property (ctl_o.sp_clear |-> !ctl_o.cpu_run) // R03
    else $error("stack clear still active while running");

  a_por_sp_top: assert property (ctl_o.sp_top |-> !ctl_o.cpu_run) // R13
    else $error("stack top request still active while running");

  a_sleep_holds: assert property (in_sleep_w && !wdt_expired_i && !hold_req_w // R17
      |=> in_sleep_w && sleep_flag_q && !wdt_flag_q)
    else $error("sleep left without a wake-up or the flags changed");
endmodule : mrsc_top
